// File: hdl/sdram_mode_reg_five_ctrl.sv
// fifth mode register of the memory device and the logic it steers
// assumes command pins are synchronous to cmd_clk; crc_err_evt comes from sys_clk logic
// Summary of operation
// [R01] controller loads the register with a mode register set command on address pins
// [R02] controller holds row, column and write strobes low during that command
// [R03] bank group, bank and address pins map to register bits 21 to 0
// [R04] a write applies only when select bits 20:18 carry 101; 111 unused
// [R05] controller writes zero to reserved bits 21, 17 and 13
// [R06] bit 12 enables read data inversion; cleared, reads pass unchanged
// [R07] bit 11 enables write inversion decoding; cleared, write data taken as is
// [R08] bit 10 enables write masking on the shared pin, writes only
// [R09] controller never enables write inversion and masking together
// [R10] multipurpose page reads ignore read inversion and return plain data
// [R11] bit 9 cleared stops parity checking while the error flag is set
// [R12] bits 8:6 select the parked termination strength
// [R13] bit 5 set turns the termination input off in power-down
// [R14] bit 5 cleared, controller keeps the termination pin valid in power-down
// [R15] parity error sets bit 4, held until cleared by a register write
// [R16] write checksum error sets bit 3, held until cleared by a register write
// [R17] bits 2:0 select parity latency off, 4, 5 or 6 clocks
// [R18] controller avoids 5 clock latency in quarter rate gear down
// [R19] with parity on, commands execute only when parity is clean
// [R20] parity covers strobes, activate and the whole address, bank and group bus
// [R21] clock enable, termination and chip select stay out of parity
`timescale 1ns/1ps
`include "mr5_consts.svh"
module sdram_mode_reg_five_ctrl
    import mr5_pkg::*;
(
    // system side
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic crc_err_evt,
    output cfg_t sys_cfg,
    // command pins
    input wire logic cmd_clk,
    input wire logic cs_n,
    input wire logic cke,
    input wire logic odt,
    input wire logic par,
    input cmd_t cmd_pins,
    // data lane
    input wire logic mpr_read,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic wr_valid,
    input wire logic [7:0] wr_dq,
    input wire logic dm_dbi_n,
    // link side results
    output logic [21:0] mode_reg_five,
    output logic cmd_exec_valid,
    output cmd_t cmd_exec,
    output logic nominal_term_en,
    output logic park_term_en,
    output logic [2:0] park_term_sel,
    output logic [7:0] rd_dq,
    output logic rd_dbi_n,
    output logic [7:0] wr_data,
    output logic wr_byte_en,
    output logic wr_valid_out
);

    function automatic logic [3:0] count_ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < `BYTE_BITS; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction : count_ones

    function automatic int tap_index(input logic [2:0] pl);
        case (pl)
            `PL_4: tap_index = `PL_4_CLK - 1;
            `PL_5: tap_index = `PL_5_CLK - 1;
            `PL_6: tap_index = `PL_6_CLK - 1;
            default: tap_index = 0;
        endcase
    endfunction : tap_index

    // reset into the link domain; first flop feeds only the second
    logic link_rst_meta;
    logic link_rstn;
    always_ff @(posedge cmd_clk) begin
        link_rst_meta <= rstn;
        link_rstn <= link_rst_meta;
    end

    // crc event crosses by toggle; spacing of three link clocks needed
    logic crc_tgl;
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            crc_tgl <= 1'b0;
        end else if (crc_err_evt) begin
            crc_tgl <= ~crc_tgl;
        end
    end
    logic crc_meta;
    logic crc_sync;
    logic crc_sync_d;
    always_ff @(posedge cmd_clk) begin
        crc_meta <= crc_tgl;
        crc_sync <= crc_meta;
        crc_sync_d <= crc_sync;
    end
    logic crc_set;
    assign crc_set = link_rstn && (crc_sync ^ crc_sync_d);

    // command capture; pins are already in this domain
    logic cap_valid;
    cmd_t cap_cmd;
    logic cap_par;
    always_ff @(posedge cmd_clk) begin
        if (!link_rstn) begin
            cap_valid <= 1'b0;
            cap_cmd <= '0;
            cap_par <= 1'b0;
        end else begin
            cap_valid <= !cs_n;
            cap_cmd <= cmd_pins;
            cap_par <= par;
        end
    end

    logic [2:0] pl_mode;
    logic par_bad;
    logic check_on;
    logic cap_ok;
    assign pl_mode = mode_reg_five[`MR5_PL_MSB:`MR5_PL_LSB];
    // even parity over everything in the command word, strobes included; no cke, odt or cs_n [R20] [R21]
    assign par_bad = (^cap_cmd) ^ cap_par;
    assign check_on = (pl_mode != `PL_OFF) &&
        (mode_reg_five[`MR5_PERSIST_BIT] || !mode_reg_five[`MR5_PAR_ERR_BIT]); // [R11] [R17]
    assign cap_ok = cap_valid && !(check_on && par_bad); // [R19]

    // latency pipe; a command failing a live parity check never enters, so it is never executed
    cmd_t pipe_cmd [0:`PIPE_DEPTH-1];
    logic pipe_vld [0:`PIPE_DEPTH-1];
    always_ff @(posedge cmd_clk) begin
        if (!link_rstn) begin
            pipe_vld[0] <= 1'b0;
            pipe_cmd[0] <= '0;
        end else begin
            pipe_vld[0] <= cap_ok; // [R19]
            pipe_cmd[0] <= cap_cmd;
        end
    end
    genvar g;
    generate
        for (g = 1; g < `PIPE_DEPTH; g++) begin : g_pipe
            always_ff @(posedge cmd_clk) begin
                if (!link_rstn) begin
                    pipe_vld[g] <= 1'b0;
                    pipe_cmd[g] <= '0;
                end else begin
                    pipe_vld[g] <= pipe_vld[g-1];
                    pipe_cmd[g] <= pipe_cmd[g-1];
                end
            end
        end
    endgenerate

    logic tap_vld;
    cmd_t tap_cmd;
    always_comb begin
        tap_vld = cap_ok;
        tap_cmd = cap_cmd;
        if (pl_mode != `PL_OFF) begin
            tap_vld = pipe_vld[tap_index(pl_mode)]; // [R17]
            tap_cmd = pipe_cmd[tap_index(pl_mode)];
        end
    end

    always_ff @(posedge cmd_clk) begin
        if (!link_rstn) begin
            cmd_exec_valid <= 1'b0;
            cmd_exec <= '0;
        end else begin
            cmd_exec_valid <= tap_vld;
            cmd_exec <= tap_cmd;
        end
    end

    // register write decode
    logic mrs_hit;
    logic [21:0] mrs_value;
    logic mr5_wr;
    assign mrs_hit = tap_vld && tap_cmd.act_n && !tap_cmd.ras_n &&
        !tap_cmd.cas_n && !tap_cmd.we_n; // [R02]
    // strobe positions 16:14 carry no register bits [R03]
    assign mrs_value = {tap_cmd.bg, tap_cmd.ba, tap_cmd.a17, 3'h0, tap_cmd.addr};
    // select 111 falls through as no write [R04]
    assign mr5_wr = mrs_hit && (mrs_value[`MR_SEL_MSB:`MR_SEL_LSB] == `MR_SEL_FIVE);

    logic par_set;
    assign par_set = cap_valid && check_on && par_bad;

    // reserved and select bits are not stored, so they read as zero [R05]
    always_ff @(posedge cmd_clk) begin
        if (!link_rstn) begin
            mode_reg_five <= `MR5_RESET;
        end else begin
            if (mr5_wr) begin
                mode_reg_five[12:5] <= mrs_value[12:5]; // [R04]
                mode_reg_five[2:0] <= mrs_value[2:0];
            end
            // a write of zero clears a flag; a new error in that cycle wins [R15]
            mode_reg_five[`MR5_PAR_ERR_BIT] <= par_set || (mode_reg_five[`MR5_PAR_ERR_BIT] &&
                !(mr5_wr && !mrs_value[`MR5_PAR_ERR_BIT]));
            mode_reg_five[`MR5_CRC_ERR_BIT] <= crc_set || (mode_reg_five[`MR5_CRC_ERR_BIT] &&
                !(mr5_wr && !mrs_value[`MR5_CRC_ERR_BIT])); // [R16]
        end
    end

    // termination: power-down is clock enable low
    logic odt_ignored;
    assign odt_ignored = !cke && mode_reg_five[`MR5_ODT_PD_BIT];
    always_ff @(posedge cmd_clk) begin
        if (!link_rstn) begin
            nominal_term_en <= 1'b0;
            park_term_en <= 1'b0;
            park_term_sel <= `PARK_OFF;
        end else begin
            nominal_term_en <= odt && !odt_ignored; // [R13]
            park_term_sel <= mode_reg_five[`MR5_PARK_MSB:`MR5_PARK_LSB]; // [R12]
            park_term_en <= (mode_reg_five[`MR5_PARK_MSB:`MR5_PARK_LSB] != `PARK_OFF) &&
                !(odt && !odt_ignored);
        end
    end

    // read lane: invert when more than half the bits are zero
    logic rd_inv;
    assign rd_inv = mode_reg_five[`MR5_RD_DBI_BIT] && !mpr_read &&
        ((4'h8 - count_ones(rd_data)) > `DBI_ZERO_LIMIT); // [R06] [R10]
    always_ff @(posedge cmd_clk) begin
        if (!link_rstn) begin
            rd_dq <= 8'h00;
            rd_dbi_n <= 1'b1;
        end else if (rd_valid) begin
            rd_dq <= rd_inv ? ~rd_data : rd_data; // [R06]
            rd_dbi_n <= !rd_inv;
        end
    end

    // write lane: shared pin decodes as inversion or as mask, never both
    always_ff @(posedge cmd_clk) begin
        if (!link_rstn) begin
            wr_data <= 8'h00;
            wr_byte_en <= 1'b0;
            wr_valid_out <= 1'b0;
        end else begin
            wr_valid_out <= wr_valid;
            if (wr_valid) begin
                // inversion takes the pin if both are set, which is illegal anyway [R09]
                wr_data <= (mode_reg_five[`MR5_WR_DBI_BIT] && !dm_dbi_n) ? ~wr_dq : wr_dq; // [R07]
                wr_byte_en <= !(mode_reg_five[`MR5_DM_BIT] && !mode_reg_five[`MR5_WR_DBI_BIT] &&
                    !dm_dbi_n); // [R08]
            end
        end
    end

    // snapshot handshake toward the system side; word held steady while in flight
    snap_state_t snap_state;
    logic [21:0] snap;
    logic snap_req;
    logic ack_meta;
    logic ack_sync;
    logic req_seen;
    always_ff @(posedge cmd_clk) begin
        ack_meta <= req_seen;
        ack_sync <= ack_meta;
    end
    always_ff @(posedge cmd_clk) begin
        if (!link_rstn) begin
            snap_state <= SNAP_IDLE;
            snap <= `MR5_RESET;
            snap_req <= 1'b0;
        end else begin
            case (snap_state)
                SNAP_IDLE: begin
                    if (mode_reg_five != snap) begin
                        snap <= mode_reg_five;
                        snap_req <= ~snap_req;
                        snap_state <= SNAP_WAIT;
                    end
                end
                SNAP_WAIT: begin
                    if (ack_sync == snap_req) begin
                        snap_state <= SNAP_IDLE;
                    end
                end
                default: snap_state <= SNAP_IDLE;
            endcase
        end
    end

    logic req_meta;
    logic req_sync;
    always_ff @(posedge sys_clk) begin
        req_meta <= snap_req;
        req_sync <= req_meta;
    end
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            req_seen <= 1'b0;
            sys_cfg <= '0;
        end else if (req_sync != req_seen) begin
            req_seen <= req_sync;
            sys_cfg <= {snap[12:3], snap[2:0]};
        end
    end

    // checks
    chk_select_gate: assert property (@(posedge cmd_clk) disable iff (!link_rstn) // [R04]
        (mrs_hit && mrs_value[`MR_SEL_MSB:`MR_SEL_LSB] != `MR_SEL_FIVE)
        |=> (mode_reg_five & `MR5_CFG_MASK) == ($past(mode_reg_five) & `MR5_CFG_MASK))
        else $error("register changed on a write to another select code");
    chk_rd_plain: assert property (@(posedge cmd_clk) disable iff (!link_rstn) // [R06]
        (rd_valid && !mode_reg_five[`MR5_RD_DBI_BIT]) |=> (rd_dbi_n && rd_dq == $past(rd_data)))
        else $error("read data inverted with read inversion off");
    chk_mpr_plain: assert property (@(posedge cmd_clk) disable iff (!link_rstn) // [R10]
        (rd_valid && mpr_read) |=> (rd_dbi_n && rd_dq == $past(rd_data)))
        else $error("page read returned inverted data");
    chk_wr_decode: assert property (@(posedge cmd_clk) disable iff (!link_rstn) // [R07]
        (wr_valid && mode_reg_five[`MR5_WR_DBI_BIT] && !dm_dbi_n) |=> wr_data == ~$past(wr_dq))
        else $error("write data not decoded");
    chk_wr_mask: assert property (@(posedge cmd_clk) disable iff (!link_rstn) // [R08]
        (wr_valid && !dm_dbi_n && mode_reg_five[`MR5_DM_BIT] && !mode_reg_five[`MR5_WR_DBI_BIT])
        |=> (!wr_byte_en && wr_valid_out))
        else $error("masked write left enabled");
    chk_par_stop: assert property (@(posedge cmd_clk) disable iff (!link_rstn) // [R11]
        (cap_valid && par_bad && pl_mode != `PL_OFF && mode_reg_five[`MR5_PAR_ERR_BIT] &&
        !mode_reg_five[`MR5_PERSIST_BIT]) |=> pipe_vld[0])
        else $error("checking went on while the flag was set");
    chk_par_drop: assert property (@(posedge cmd_clk) disable iff (!link_rstn) // [R19]
        (cap_valid && check_on && par_bad) |=> (!pipe_vld[0] && mode_reg_five[`MR5_PAR_ERR_BIT]))
        else $error("bad parity command kept or flag not set");
    chk_par_sticky: assert property (@(posedge cmd_clk) disable iff (!link_rstn) // [R15]
        (mode_reg_five[`MR5_PAR_ERR_BIT] && !mr5_wr) |=> mode_reg_five[`MR5_PAR_ERR_BIT])
        else $error("parity flag dropped without a write");
    chk_crc_set: assert property (@(posedge cmd_clk) disable iff (!link_rstn) // [R16]
        crc_set |=> mode_reg_five[`MR5_CRC_ERR_BIT])
        else $error("checksum flag not set");
    chk_pl_four: assert property (@(posedge cmd_clk) disable iff (!link_rstn) // [R17]
        (cap_ok && pl_mode == `PL_4 && !mrs_hit) ##1 (!mrs_hit)[*4] |=> cmd_exec_valid)
        else $error("command not executed four clocks later");
    chk_odt_pd: assert property (@(posedge cmd_clk) disable iff (!link_rstn) // [R13]
        (!cke && mode_reg_five[`MR5_ODT_PD_BIT]) |=> !nominal_term_en)
        else $error("termination input used in power-down");
    chk_park_sel: assert property (@(posedge cmd_clk) disable iff (!link_rstn) // [R12]
        $rose(mr5_wr) |=> ##1 park_term_sel == $past(mode_reg_five[8:6]))
        else $error("parked selection not following register");
    cov_mrs_write: cover property (@(posedge cmd_clk) disable iff (!link_rstn) mr5_wr);
    cov_par_err: cover property (@(posedge cmd_clk) disable iff (!link_rstn) par_set);
    cov_crc_err: cover property (@(posedge cmd_clk) disable iff (!link_rstn) crc_set);
    cov_rd_inv: cover property (@(posedge cmd_clk) disable iff (!link_rstn) rd_valid && rd_inv);
    cov_sys_copy: cover property (@(posedge sys_clk) disable iff (!rstn) req_sync != req_seen);

endmodule : sdram_mode_reg_five_ctrl

// File: inc/mr5_consts.svh
// constants for the fifth mode register block: bit positions, codes, counts
// assumes inclusion by bare name from the package and the design file
`ifndef MR5_CONSTS_SVH
`define MR5_CONSTS_SVH
`define MR5_WIDTH 22
`define MR5_RESET 22'h000000
`define MR5_CFG_MASK 22'h001FE7
`define MR_SEL_MSB 20
`define MR_SEL_LSB 18
`define MR_SEL_FIVE 3'h5
`define MR_SEL_DNU 3'h7
`define MR5_RD_DBI_BIT 12
`define MR5_WR_DBI_BIT 11
`define MR5_DM_BIT 10
`define MR5_PERSIST_BIT 9
`define MR5_PARK_MSB 8
`define MR5_PARK_LSB 6
`define MR5_ODT_PD_BIT 5
`define MR5_PAR_ERR_BIT 4
`define MR5_CRC_ERR_BIT 3
`define MR5_PL_MSB 2
`define MR5_PL_LSB 0
`define PL_OFF 3'h0
`define PL_4 3'h1
`define PL_5 3'h2
`define PL_6 3'h3
`define PL_4_CLK 4
`define PL_5_CLK 5
`define PL_6_CLK 6
`define PIPE_DEPTH 6
`define PARK_OFF 3'h0
`define DBI_ZERO_LIMIT 4'h4
`define BYTE_BITS 8
`endif

// File: inc/mr5_pkg.sv
// types shared by the fifth mode register block
// assumes mr5_consts.svh on the include path
`include "mr5_consts.svh"
package mr5_pkg;
    // one command as sampled on the command pins
    typedef struct packed {
        logic act_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bg;
        logic [1:0] ba;
        logic a17;
        logic [13:0] addr;
    } cmd_t;
    // decoded settings as seen on the system side
    typedef struct packed {
        logic rd_dbi;
        logic wr_dbi;
        logic dm;
        logic persist;
        logic [2:0] park;
        logic odt_pd_off;
        logic par_err;
        logic crc_err;
        logic [2:0] pl;
    } cfg_t;
    typedef enum logic [1:0] {
        SNAP_IDLE = 2'b01,
        SNAP_WAIT = 2'b10
    } snap_state_t;
endpackage : mr5_pkg

// File: sim/ddr_ctrl_model.sv
// controller model: drives the command pins of the mode register block
// assumes the bench calls its tasks between cmd_clk edges
`timescale 1ns/1ps
module ddr_ctrl_model
    import mr5_pkg::*;
(
    // link clock
    input wire logic cmd_clk,
    // command pins
    output logic cs_n,
    output logic cke,
    output logic odt,
    output logic par,
    output cmd_t cmd_pins
);
    // odt always at a valid level, power-down or not
    // no gear-down mode here, so any latency code is legal
    initial begin
        cs_n = 1'b1;
        cke = 1'b1;
        odt = 1'b0;
        par = 1'b0;
        cmd_pins = '0;
    end
    task automatic levels(input logic k, input logic o);
        @(posedge cmd_clk);
        cke <= k;
        odt <= o;
    endtask : levels
    // one command for one edge; bad flips the parity bit
    task automatic issue(input cmd_t c, input logic bad);
        @(posedge cmd_clk);
        cs_n <= 1'b0;
        cmd_pins <= c;
        par <= ^c ^ bad;
        @(posedge cmd_clk);
        cs_n <= 1'b1;
        // released pins show the inverse, never a stale copy
        cmd_pins <= ~c;
        par <= ~par;
    endtask : issue
    function automatic cmd_t mrs_cmd(input logic [21:0] v);
        cmd_t c;
        c.act_n = 1'b1;
        c.ras_n = 1'b0;
        c.cas_n = 1'b0;
        c.we_n = 1'b0;
        c.bg = {1'b0, v[20]};
        c.ba = v[19:18];
        c.a17 = 1'b0;
        c.addr = {1'b0, v[12:0]};
        return c;
    endfunction : mrs_cmd
endmodule : ddr_ctrl_model

// File: sim/tb_top.sv
// bench for the fifth mode register block
// assumes the controller model drives all command pins
`timescale 1ns/1ps
module tb_top;
    import mr5_pkg::*;
    logic sys_clk = 1'b0;
    logic cmd_clk = 1'b0;
    logic rstn = 1'b0;
    logic crc_err_evt = 1'b0;
    logic mpr_read = 1'b0;
    logic rd_valid = 1'b0;
    logic [7:0] rd_data = 8'h00;
    logic wr_valid = 1'b0;
    logic [7:0] wr_dq = 8'h00;
    logic dm_dbi_n = 1'b1;
    logic cs_n, cke, odt, par, cmd_exec_valid, nominal_term_en, park_term_en;
    logic rd_dbi_n, wr_byte_en, wr_valid_out;
    cmd_t cmd_pins, cmd_exec;
    cfg_t sys_cfg;
    logic [21:0] mode_reg_five;
    logic [2:0] park_term_sel;
    logic [7:0] rd_dq, wr_data;
    int fails = 0;
    int total_checks = 0;
    int n;
    // refresh-like command, parity covers every field
    localparam cmd_t REF_C = cmd_t'({4'h9, 19'h12345});
    always #50 sys_clk = ~sys_clk;
    // 48 ns link clock; its rising edges never meet those of sys_clk
    always #24 cmd_clk = ~cmd_clk;
    ddr_ctrl_model i_ctrl (.cmd_clk, .cs_n, .cke, .odt, .par, .cmd_pins);
    sdram_mode_reg_five_ctrl i_dut (.sys_clk, .rstn, .crc_err_evt, .sys_cfg, .cmd_clk,
        .cs_n, .cke, .odt, .par, .cmd_pins, .mpr_read, .rd_valid, .rd_data, .wr_valid,
        .wr_dq, .dm_dbi_n, .mode_reg_five, .cmd_exec_valid, .cmd_exec, .nominal_term_en,
        .park_term_en, .park_term_sel, .rd_dq, .rd_dbi_n, .wr_data, .wr_byte_en,
        .wr_valid_out);
    task automatic cmp(input logic [23:0] got, input logic [23:0] want);
        total_checks++;
        if (got !== want) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : cmp
    // latency counts, in link clock edges
    task automatic cmp_cnt(input int got, input int want);
        total_checks++;
        if (got != want) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask : cmp_cnt
    task automatic conclude();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    task automatic idle(input int k);
        repeat (k) @(posedge cmd_clk);
        #1;
    endtask : idle
    // n = link edges to execution, 12 when dropped
    task automatic run(input cmd_t c, input logic bad);
        i_ctrl.issue(c, bad);
        n = 0;
        do begin
            idle(1);
            n++;
        end while (cmd_exec_valid !== 1'b1 && n < 12);
        if (cmd_exec_valid === 1'b1)
            cmp(cmd_exec, c);
    endtask : run
    function automatic logic [21:0] mv(input logic [2:0] s, input logic [12:0] lo);
        return {1'b0, s, 5'h00, lo};
    endfunction : mv
    // settle time lets a changed latency tap drain
    task automatic mrs(input logic [21:0] v);
        run(i_ctrl.mrs_cmd(v), 1'b0);
        idle(10);
    endtask : mrs
    task automatic rd(input logic [7:0] d, input logic m, input logic [8:0] want);
        @(posedge cmd_clk);
        rd_valid <= 1'b1;
        rd_data <= d;
        mpr_read <= m;
        @(posedge cmd_clk);
        rd_valid <= 1'b0;
        #1;
        cmp({rd_dbi_n, rd_dq}, want);
    endtask : rd
    task automatic wr(input logic [7:0] d, input logic p, input logic [9:0] want);
        @(posedge cmd_clk);
        wr_valid <= 1'b1;
        wr_dq <= d;
        dm_dbi_n <= p;
        @(posedge cmd_clk);
        wr_valid <= 1'b0;
        dm_dbi_n <= 1'b1;
        #1;
        cmp({wr_valid_out, wr_byte_en, wr_data}, want);
    endtask : wr
    initial begin
        #1000000;
        fails++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        cmp({mode_reg_five, rd_dbi_n}, 23'h000001);
        idle(6);
        mrs(mv(3'h5, 13'h1000));
        cmp_cnt(n, 1);
        cmp(mode_reg_five, 22'h001000);
        for (int s = 0; s < 8; s++)
            if (s != 5) begin
                mrs(mv(s[2:0], 13'h0FFF));
                cmp(mode_reg_five, 22'h001000);
            end
        rd(8'h00, 1'b0, 9'h0FF);
        rd(8'h0F, 1'b0, 9'h10F);
        rd(8'h00, 1'b1, 9'h100);
        mrs(mv(3'h5, 13'h0800));
        wr(8'hA5, 1'b0, 10'h35A);
        wr(8'hA5, 1'b1, 10'h3A5);
        rd(8'h00, 1'b0, 9'h100);
        mrs(mv(3'h5, 13'h0400));
        wr(8'hA5, 1'b0, 10'h2A5);
        wr(8'h3C, 1'b1, 10'h33C);
        rd(8'h00, 1'b0, 9'h100);
        for (int p = 0; p < 8; p++) begin
            mrs(mv(3'h5, 13'(p << 6)));
            cmp({park_term_en, park_term_sel}, {p != 0, p[2:0]});
        end
        i_ctrl.levels(1'b0, 1'b1);
        idle(3);
        cmp({nominal_term_en, park_term_en}, 2'b10);
        i_ctrl.levels(1'b1, 1'b1);
        mrs(mv(3'h5, 13'h0060));
        i_ctrl.levels(1'b0, 1'b1);
        idle(3);
        cmp({nominal_term_en, park_term_en}, 2'b01);
        i_ctrl.levels(1'b1, 1'b0);
        for (int c = 0; c < 4; c++) begin
            mrs(mv(3'h5, 13'(c)));
            run(REF_C, 1'b0);
            cmp_cnt(n, (c == 0) ? 1 : c + 4);
        end
        run(REF_C, 1'b1);
        cmp_cnt(n, 12);
        cmp(mode_reg_five, 22'h000013);
        run(REF_C, 1'b1);
        cmp_cnt(n, 7);
        cmp(mode_reg_five, 22'h000013);
        mrs(mv(3'h5, 13'h0213));
        cmp(mode_reg_five, 22'h000213);
        mrs(mv(3'h5, 13'h0203));
        cmp(mode_reg_five, 22'h000203);
        // checking is live here, so a wrongly covered termination pin would drop the command
        i_ctrl.levels(1'b1, 1'b1);
        run(REF_C, 1'b0);
        cmp_cnt(n, 7);
        i_ctrl.levels(1'b1, 1'b0);
        repeat (2) begin
            run(REF_C, 1'b1);
            cmp_cnt(n, 12);
            cmp(mode_reg_five, 22'h000213);
        end
        mrs(mv(3'h5, 13'h0000));
        @(posedge sys_clk);
        crc_err_evt <= 1'b1;
        @(posedge sys_clk);
        crc_err_evt <= 1'b0;
        idle(8);
        cmp(mode_reg_five, 22'h000008);
        repeat (8) @(posedge sys_clk);
        #1;
        cmp(sys_cfg, 13'h0008);
        mrs(mv(3'h5, 13'h0008));
        cmp(mode_reg_five, 22'h000008);
        mrs(mv(3'h5, 13'h0000));
        cmp(mode_reg_five, 22'h000000);
        conclude();
    end
endmodule : tb_top
